// >>> verilog/tdd_pkg.sv
`default_nettype none
package tdd_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_DESC0 = 8'h00;
  localparam logic [7:0] OFF_CPU_ADDR = 8'h14;
  localparam logic [7:0] OFF_CPU_IDX = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_CLEAR = 8'h20;
  localparam logic [7:0] OFF_ENABLE = 8'h24;
  localparam logic [7:0] OFF_EXEC = 8'h28;
  // ==========================================================
  // descriptor field positions
  localparam int MULT_LSB = 29;
  localparam int MPS_LSB = 18;
  localparam int BYTES_LSB = 3;
  localparam int VALID_BIT = 0;
  localparam int SPLIT_BIT = 14;
  localparam int HUB_ADDR_LSB = 25;
  localparam int HUB_PORT_LSB = 18;
  localparam int SE_LSB = 16;
  localparam int BUF_LSB = 8;
  localparam int PERIOD_LSB = 3;
  localparam int BRANCH_BIT = 5;
  localparam int NEXT_LSB = 0;
  // writable bits of descriptor words 4..0
  localparam logic [4:0][31:0] DESC_WMASK = {32'h0000_003F, 32'h0078_00FF,
    32'h1EFF_FFF8, 32'hFFFF_4000, 32'h7FFF_FFF8};
  // ==========================================================
  // address conversion, status bits, bus answers
  localparam logic [31:0] CPU_BASE = 32'h0000_0400;
  localparam int CPU_SHIFT = 3;
  localparam int STS_DONE = 0;
  localparam int STS_FATAL = 1;
  localparam int STS_CFG = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// >>> verilog/tdd_poll_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tdd_poll_if;
  logic tick;
  logic [7:0] mask;
  logic [4:0] period;
  logic due;
  logic bad;
  modport ctrl (output tick, output mask, output period, input due, input bad);
  modport sched (input tick, input mask, input period, output due, output bad);
endinterface
`default_nettype wire

// >>> verilog/tdd_poll_sched.sv
`timescale 1ns/10ps
`default_nettype none
module tdd_poll_sched (
  input wire logic clk_in,
  input wire logic rst_in,
  tdd_poll_if.sched poll
);
  typedef struct packed {
    logic [7:0] uf;
  } tdd_sched_state_t;
  tdd_sched_state_t q, d;
  logic [4:0] span;
  // ==========================================================
  // microframe counter: low 3 bits pick the mask bit, top 5 count ms
  always_comb begin
    d = q;
    if (poll.tick) begin
      d.uf = q.uf + 8'h01;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  // interval mask from the highest set selector bit
  assign span = {poll.period[4], |poll.period[4:3], |poll.period[4:2],
    |poll.period[4:1], |poll.period};
  assign poll.due = poll.tick && poll.mask[q.uf[2:0]]
    && ((q.uf[7:3] & span) == 5'h00);
  // ms polling needs exactly one mask bit; an empty mask never polls
  assign poll.bad = (poll.mask == 8'h00)
    || ((poll.period != 5'h00) && !$onehot(poll.mask));
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_subms_every: assert property (
    poll.tick && poll.period == 5'h00 && poll.mask == 8'hFF |-> poll.due)
    else $error("full mask did not poll");
  chk_ms_align: assert property (
    poll.due && poll.period == 5'h01 |-> q.uf[3] == 1'b0)
    else $error("2 ms poll off its frame");
endmodule // tdd_poll_sched
`default_nettype wire

// >>> verilog/tdd_addr_conv.sv
`timescale 1ns/10ps
`default_nettype none
module tdd_addr_conv (
  input wire logic [31:0] cpu_addr_in,
  output logic [15:0] buf_idx_out,
  output logic range_err_out
);
  logic [31:0] offs;
  // ==========================================================
  // cpu byte address to 8-byte memory slot
  assign offs = cpu_addr_in - tdd_pkg::CPU_BASE;
  assign buf_idx_out = offs[tdd_pkg::CPU_SHIFT +: 16];
  // below the base or past 16 index bits cannot be expressed
  assign range_err_out = (cpu_addr_in < tdd_pkg::CPU_BASE) || (|offs[31:19]);
endmodule // tdd_addr_conv
`default_nettype wire

// >>> verilog/tdd_top.sv
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
module tdd_top #(
  parameter int IDX_W = 5
) (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic [7:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [7:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic UFRAME_TICK_IN,
  output logic PKT_REQ_OUT,
  output logic [10:0] PKT_LEN_OUT,
  output logic [15:0] PKT_BUF_IDX_OUT,
  output logic PKT_SPLIT_OUT,
  output logic [6:0] PKT_HUB_ADDR_OUT,
  output logic [6:0] PKT_HUB_PORT_OUT,
  output logic [1:0] PKT_START_END_OUT,
  input wire logic PKT_ACK_IN,
  input wire logic [10:0] PKT_BYTES_IN,
  input wire logic PKT_FATAL_IN,
  output logic [IDX_W-1:0] DESC_IDX_OUT,
  output logic IRQ_OUT
);
  typedef enum logic [1:0] {
    TDD_IDLE,
    TDD_WAIT_SLOT,
    TDD_XFER
  } tdd_fsm_t;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [4:0][31:0] desc;
    logic [31:0] cpu_addr;
    logic [15:0] cpu_idx;
    logic [2:0] sts;
    logic [2:0] ena;
    tdd_fsm_t fsm;
    logic [14:0] rem;
    logic [1:0] pkts;
    logic [10:0] len;
    logic [15:0] buf_idx;
    logic [IDX_W-1:0] cur_idx;
  } tdd_state_t;

  tdd_state_t q, d;
  tdd_poll_if poll ();
  logic [15:0] conv_idx;
  logic conv_err;
  logic wr_go;
  logic [31:0] wr_word;
  logic [1:0] mult;
  logic [10:0] mps;
  logic [10:0] got;
  logic [14:0] rem_left;
  logic finish;
  logic sw_set;
  logic clr_wr;
  logic [IDX_W-1:0] nxt_idx;

  // ==========================================================
  // decode helpers
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= tdd_pkg::OFF_EXEC);
  endfunction

  // read view of every register; write-only clear reads zero
  function automatic logic [31:0] rd(input logic [7:0] a);
    rd = 32'h0000_0000;
    if (mapped(a) && a < tdd_pkg::OFF_CPU_ADDR) begin
      rd = q.desc[a[4:2]];
    end else begin
      case (a)
        tdd_pkg::OFF_CPU_ADDR: rd = q.cpu_addr;
        tdd_pkg::OFF_CPU_IDX: rd = {16'h0000, q.cpu_idx};
        tdd_pkg::OFF_STATUS: rd = {29'h0000_0000, q.sts};
        tdd_pkg::OFF_ENABLE: rd = {29'h0000_0000, q.ena};
        tdd_pkg::OFF_EXEC: rd = {1'b0, q.rem, 8'(q.cur_idx), 4'h0, q.pkts, 2'(q.fsm)};
        default: rd = 32'h0000_0000;
      endcase
    end
  endfunction

  // byte-lane merge of a strobed write over the current value
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      lanes[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // next packet size: whatever is left, but never above one packet
  function automatic logic [10:0] cap(input logic [14:0] r, input logic [10:0] m);
    cap = (r < 15'(m)) ? r[10:0] : m;
  endfunction

  // ==========================================================
  // polling schedule and address conversion
  assign poll.tick = UFRAME_TICK_IN;
  assign poll.mask = q.desc[3][7:0];
  assign poll.period = q.desc[2][tdd_pkg::PERIOD_LSB +: 5];

  tdd_poll_sched u_sched (
    .clk_in(CLK_SYS_IN),
    .rst_in(RESET_IN),
    .poll(poll)
  );

  tdd_addr_conv u_conv (
    .cpu_addr_in(wr_word),
    .buf_idx_out(conv_idx),
    .range_err_out(conv_err)
  );

  // ==========================================================
  // descriptor field taps and transfer arithmetic
  assign mult = q.desc[0][tdd_pkg::MULT_LSB +: 2];
  assign mps = q.desc[0][tdd_pkg::MPS_LSB +: 11];
  assign wr_go = q.aw_got && q.w_got && !q.bvalid;
  assign wr_word = lanes(rd(q.waddr), q.wdata, q.wstrb);
  assign sw_set = wr_go && q.waddr == tdd_pkg::OFF_DESC0 && wr_word[tdd_pkg::VALID_BIT];
  assign clr_wr = wr_go && q.waddr == tdd_pkg::OFF_CLEAR;
  // a device that answers with more than asked is clipped to the request
  assign got = (PKT_BYTES_IN < q.len) ? PKT_BYTES_IN : q.len;
  assign rem_left = q.rem - 15'(got);
  // done on fatal error, on all bytes moved, or on a short packet
  assign finish = q.fsm == TDD_XFER && PKT_ACK_IN
    && (PKT_FATAL_IN || rem_left == 15'h0000 || got < q.len);
  assign nxt_idx = q.desc[4][tdd_pkg::BRANCH_BIT]
    ? q.desc[4][tdd_pkg::NEXT_LSB +: IDX_W] : q.cur_idx + IDX_W'(1);

  // ==========================================================
  // next state: bus slave, transfer engine, register writes
  always_comb begin
    logic [2:0] sts_set;
    logic [2:0] sts_clr;
    logic [2:0] wi;
    sts_set = 3'h0;
    sts_clr = 3'h0;
    wi = q.waddr[4:2];
    d = q;
    // write address and data are captured in either order
    if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
      d.aw_got = 1'b1;
      d.waddr = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
      d.w_got = 1'b1;
      d.wdata = S_AXI_WDATA_IN;
      d.wstrb = S_AXI_WSTRB_IN;
    end
    if (q.bvalid && S_AXI_BREADY_IN) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && S_AXI_RREADY_IN) begin
      d.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
      d.rvalid = 1'b1;
      d.rdata = rd(S_AXI_ARADDR_IN);
      d.rresp = mapped(S_AXI_ARADDR_IN) ? tdd_pkg::RESP_OKAY : tdd_pkg::RESP_SLVERR;
    end
    // transfer engine
    case (q.fsm)
      TDD_IDLE: begin
        if (q.desc[0][tdd_pkg::VALID_BIT]) begin
          if (mult == 2'h0 || poll.bad) begin
            // undefined multiplier or schedule: retire instead of guessing
            d.desc[0][tdd_pkg::VALID_BIT] = 1'b0;
            sts_set[tdd_pkg::STS_CFG] = 1'b1;
            d.cur_idx = nxt_idx;
          end else begin
            d.rem = q.desc[0][tdd_pkg::BYTES_LSB +: 15];
            d.buf_idx = q.desc[2][tdd_pkg::BUF_LSB +: 16];
            d.fsm = TDD_WAIT_SLOT;
          end
        end
      end
      TDD_WAIT_SLOT: begin
        if (poll.due) begin
          d.pkts = mult;
          d.len = cap(q.rem, mps);
          d.fsm = TDD_XFER;
        end
      end
      TDD_XFER: begin
        if (PKT_ACK_IN) begin
          d.rem = rem_left;
          d.buf_idx = q.buf_idx + 16'(got >> 3);
          if (finish) begin
            d.desc[0][tdd_pkg::VALID_BIT] = 1'b0;
            sts_set[PKT_FATAL_IN ? tdd_pkg::STS_FATAL : tdd_pkg::STS_DONE] = 1'b1;
            d.cur_idx = nxt_idx;
            d.fsm = TDD_IDLE;
          end else if (q.pkts == 2'h1) begin
            // burst used up: wait for the next polling slot
            d.fsm = TDD_WAIT_SLOT;
          end else begin
            d.pkts = q.pkts - 2'h1;
            d.len = cap(rem_left, mps);
          end
        end
      end
      default: d.fsm = TDD_IDLE;
    endcase
    // software write comes last so a fresh valid beats a retire
    if (wr_go) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = mapped(q.waddr) ? tdd_pkg::RESP_OKAY : tdd_pkg::RESP_SLVERR;
      if (mapped(q.waddr) && q.waddr < tdd_pkg::OFF_CPU_ADDR) begin
        // valid can only be set here; clearing is the engine's job
        d.desc[wi] = (d.desc[wi] & ~tdd_pkg::DESC_WMASK[wi])
          | (wr_word & tdd_pkg::DESC_WMASK[wi]);
        if (sw_set) begin
          d.desc[0][tdd_pkg::VALID_BIT] = 1'b1;
        end
      end else begin
        case (q.waddr)
          tdd_pkg::OFF_CPU_ADDR: begin
            d.cpu_addr = wr_word;
            d.cpu_idx = conv_idx;
            sts_set[tdd_pkg::STS_CFG] = conv_err;
          end
          tdd_pkg::OFF_CLEAR: sts_clr = wr_word[2:0];
          tdd_pkg::OFF_ENABLE: d.ena = wr_word[2:0];
          default: d.ena = q.ena;
        endcase
      end
    end
    // sticky status: a set in the clearing cycle survives
    d.sts = (q.sts & ~sts_clr) | sts_set;
  end

  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign S_AXI_AWREADY_OUT = !q.aw_got && !q.bvalid;
  assign S_AXI_WREADY_OUT = !q.w_got && !q.bvalid;
  assign S_AXI_BVALID_OUT = q.bvalid;
  assign S_AXI_BRESP_OUT = q.bresp;
  assign S_AXI_ARREADY_OUT = !q.rvalid;
  assign S_AXI_RVALID_OUT = q.rvalid;
  assign S_AXI_RDATA_OUT = q.rdata;
  assign S_AXI_RRESP_OUT = q.rresp;
  assign PKT_REQ_OUT = q.fsm == TDD_XFER;
  assign PKT_LEN_OUT = q.len;
  assign PKT_BUF_IDX_OUT = q.buf_idx;
  assign PKT_SPLIT_OUT = q.desc[1][tdd_pkg::SPLIT_BIT];
  // hub routing only matters when the split flag is set
  assign PKT_HUB_ADDR_OUT = q.desc[1][tdd_pkg::HUB_ADDR_LSB +: 7];
  assign PKT_HUB_PORT_OUT = q.desc[1][tdd_pkg::HUB_PORT_LSB +: 7];
  assign PKT_START_END_OUT = q.desc[1][tdd_pkg::SE_LSB +: 2];
  assign DESC_IDX_OUT = q.cur_idx;
  assign IRQ_OUT = |(q.sts & q.ena);

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);

  sequence seq_finish;
    finish && !sw_set;
  endsequence

  sequence seq_slot_start;
    q.fsm == TDD_WAIT_SLOT && poll.due;
  endsequence

  chk_valid_retire: assert property (seq_finish |=> !q.desc[0][0])
    else $error("valid not cleared after finish");
  chk_next_index: assert property (seq_finish |=> q.cur_idx == $past(nxt_idx))
    else $error("wrong next descriptor index");
  chk_pkt_cap: assert property (
    PKT_REQ_OUT |-> PKT_LEN_OUT <= mps && 15'(PKT_LEN_OUT) <= q.rem)
    else $error("packet longer than allowed");
  chk_burst_load: assert property (
    seq_slot_start |=> q.fsm == TDD_XFER && q.pkts == $past(mult))
    else $error("burst count not loaded from multiplier");
  chk_slot_hold: assert property (
    q.fsm == TDD_WAIT_SLOT && !poll.due |=> q.fsm == TDD_WAIT_SLOT)
    else $error("packet issued outside a polling slot");
  chk_len_load: assert property (
    q.fsm == TDD_IDLE && q.desc[0][0] && mult != 2'h0 && !poll.bad
    |=> q.rem == $past(q.desc[0][17:3]))
    else $error("byte count not taken");
  chk_addr_convert: assert property (
    wr_go && q.waddr == tdd_pkg::OFF_CPU_ADDR
    |=> q.cpu_idx == 16'(($past(wr_word) - 32'h0000_0400) >> 3))
    else $error("buffer index conversion wrong");
  chk_sticky_hold: assert property (
    q.sts[tdd_pkg::STS_DONE] && !clr_wr |=> q.sts[tdd_pkg::STS_DONE])
    else $error("done status lost without clear");
endmodule // tdd_top
`default_nettype wire

// >>> verification/tdd_usb_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// far-side endpoint: answers each packet request once
module tdd_usb_partner (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic [10:0] len_in,
  input wire logic [3:0] delay_in,
  input wire logic short_in,
  input wire logic fatal_in,
  output logic ack_out,
  output logic [10:0] bytes_out,
  output logic fatal_out
);
  logic [3:0] wait_q;
  // ack after delay_in idle cycles; skip the cycle of our own ack so one request
  // is never answered twice
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_q <= 4'h0;
      ack_out <= 1'b0;
      fatal_out <= 1'b0;
      bytes_out <= 11'h000;
    end else begin
      ack_out <= 1'b0;
      fatal_out <= 1'b0;
      bytes_out <= ~bytes_out; // released lines toggle and hold the last count every other cycle
      if (req_in && !ack_out) begin
        if (wait_q >= delay_in) begin
          ack_out <= 1'b1;
          fatal_out <= fatal_in;
          bytes_out <= short_in ? len_in - 11'h001 : len_in;
          wait_q <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule // tdd_usb_partner
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, tick, shrt, fat;
  logic awready, wready, bvalid, arready, rvalid, req, split, ack, pfat, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, dly;
  logic [1:0] bresp, rresp, se;
  logic [10:0] plen, pbytes;
  logic [15:0] pbuf;
  logic [6:0] hub, port;
  logic [4:0] idx;
  int bad_count, samples_checked, ticks;
  logic [10:0] q_len[$];
  logic [15:0] q_buf[$];
  logic [16:0] q_hdr[$];
  int q_tick[$];
  int per[10] = '{0, 0, 0, 0, 1, 2, 3, 4, 8, 16};
  logic [7:0] msk[10] = '{8'hFF, 8'hAA, 8'h11, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
  int iv[10] = '{1, 2, 4, 8, 16, 32, 32, 64, 128, 256};

  tdd_top #(.IDX_W(5)) i_dut (
    .CLK_SYS_IN(clk), .RESET_IN(rst), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb),
    .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .UFRAME_TICK_IN(tick), .PKT_REQ_OUT(req), .PKT_LEN_OUT(plen), .PKT_BUF_IDX_OUT(pbuf),
    .PKT_SPLIT_OUT(split), .PKT_HUB_ADDR_OUT(hub), .PKT_HUB_PORT_OUT(port),
    .PKT_START_END_OUT(se), .PKT_ACK_IN(ack), .PKT_BYTES_IN(pbytes), .PKT_FATAL_IN(pfat),
    .DESC_IDX_OUT(idx), .IRQ_OUT(irq));
  tdd_usb_partner i_ep (.clk_in(clk), .rst_in(rst), .req_in(req), .len_in(plen),
    .delay_in(dly), .short_in(shrt), .fatal_in(fat), .ack_out(ack), .bytes_out(pbytes),
    .fatal_out(pfat));

  // ==========================================================
  // clock, microframe ticks, packet monitor
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // one tick every 12 cycles, counted so polling intervals can be measured
  initial begin
    tick = 1'b0;
    ticks = 0;
    forever begin
      repeat (11) @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      ticks++;
    end
  end
  // sampled at the falling edge, where the ack cycle is settled
  always @(negedge clk) begin
    if (req === 1'b1 && ack === 1'b1) begin
      q_len.push_back(plen);
      q_buf.push_back(pbuf);
      q_hdr.push_back({split, hub, port, se});
      q_tick.push_back(ticks);
    end
  end

  // ==========================================================
  // checking and bus tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // address and data offered together, each dropped at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic pa, pw, ta, tw, t;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    t = 1'b0;
    while (pa || pw) begin
      #1 ta = pa && awready;
      tw = pw && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    while (!t) begin
      #1 t = bvalid;
      r = bresp;
      @(posedge clk);
    end
    chk(32'(r), 32'(er));
  endtask
  task automatic rx(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    araddr <= a;
    arvalid <= 1'b1;
    t = 1'b0;
    while (!t) begin
      #1 t = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      #1 t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0] r;
    rx(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask
  // load words 1..4, hand over word 0 last, then poll until retired
  task automatic run(input logic [1:0] m, input logic [10:0] mps, input logic [14:0] tot,
                     input logic [31:0] w1, input logic [31:0] w2, input logic [31:0] w3,
                     input logic [31:0] w4);
    logic [31:0] d;
    logic [1:0] r;
    q_len.delete();
    q_buf.delete();
    q_hdr.delete();
    q_tick.delete();
    wr(8'h04, w1);
    wr(8'h08, w2);
    wr(8'h0C, w3);
    wr(8'h10, w4);
    wr(tdd_pkg::OFF_DESC0, {1'b0, m, mps, tot, 3'b001});
    d = 32'h0000_0001;
    while (d[0] !== 1'b0) rx(tdd_pkg::OFF_DESC0, d, r);
  endtask
  task automatic fin(input logic [31:0] sts);
    rd(tdd_pkg::OFF_STATUS, sts);
    chk(32'(irq), 32'h0000_0001);
    wr(tdd_pkg::OFF_CLEAR, 32'h0000_0007);
    chk(32'(irq), 32'h0000_0000);
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // test sequence
  initial begin
    rst = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    dly = 4'h0;
    shrt = 1'b0;
    fat = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(tdd_pkg::OFF_STATUS, 32'h0000_0000);
    chk(32'(idx), 32'h0000_0000);
    // all-ones writes keep only the field bits; valid written 0 stays clear
    for (int i = 0; i < 5; i++) begin
      wr(8'(4 * i), 32'hFFFF_FFFE);
      rd(8'(4 * i), tdd_pkg::DESC_WMASK[i] & 32'hFFFF_FFFE);
    end
    wr(tdd_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    rd(tdd_pkg::OFF_STATUS, 32'h0000_0000);
    rd(tdd_pkg::OFF_CLEAR, 32'h0000_0000);
    wr(8'h2C, 32'h0000_0001, tdd_pkg::RESP_SLVERR);
    rd(8'h2C, 32'h0000_0000, tdd_pkg::RESP_SLVERR);
    wr(8'h02, 32'h0000_0001, tdd_pkg::RESP_SLVERR);
    wr(tdd_pkg::OFF_ENABLE, 32'hFFFF_FFFF);
    rd(tdd_pkg::OFF_ENABLE, 32'h0000_0007);
    wr(tdd_pkg::OFF_CPU_ADDR, 32'h0000_0C08);
    rd(tdd_pkg::OFF_CPU_IDX, 32'h0000_0101);
    // byte strobes merge one lane over the current word
    wstrb <= 4'h1;
    wr(tdd_pkg::OFF_CPU_ADDR, 32'hFFFF_FF10);
    wstrb <= 4'hF;
    rd(tdd_pkg::OFF_CPU_ADDR, 32'h0000_0C10);
    rd(tdd_pkg::OFF_CPU_IDX, 32'h0000_0102);
    // an address below the buffer base cannot be converted
    wr(tdd_pkg::OFF_CPU_ADDR, 32'h0000_03F8);
    fin(32'h0000_0004);
    $display("test registers done");
    // one packet per microframe, last packet short of the limit
    run(2'b01, 11'h008, 15'h0014, 32'h0, 32'h0000_1000, 32'h0000_00FF, 32'h0);
    chk(32'(q_len.size()), 32'h0000_0003);
    for (int i = 0; i < 3; i++) begin
      chk(32'(q_len[i]), (i < 2) ? 32'h0000_0008 : 32'h0000_0004);
      chk(32'(q_buf[i]), 32'h0000_0010 + 32'(i));
      if (i > 0) chk(32'(q_tick[i] - q_tick[i - 1]), 32'h0000_0001);
    end
    fin(32'h0000_0001);
    chk(32'(idx), 32'h0000_0001);
    rd(tdd_pkg::OFF_EXEC, 32'h0000_0104);
    $display("test single done");
    // burst of three in one slot, split through a hub, then a branch
    run(2'b11, 11'h008, 15'h0018, 32'h5456_4000, 32'h0, 32'h0000_0001, 32'h0000_0037);
    chk(32'(q_len.size()), 32'h0000_0003);
    for (int i = 0; i < 3; i++) begin
      chk(32'(q_tick[i]), 32'(q_tick[0]));
      chk(32'(q_hdr[i]), {15'h0000, 1'b1, 7'h2A, 7'h15, 2'b10});
    end
    fin(32'h0000_0001);
    chk(32'(idx), 32'h0000_0017);
    $display("test burst done");
    // slow endpoint returns a short packet: descriptor ends early
    dly <= 4'h5;
    shrt <= 1'b1;
    run(2'b01, 11'h008, 15'h0018, 32'h0, 32'h0, 32'h0000_00FF, 32'h0);
    chk(32'(q_len.size()), 32'h0000_0001);
    fin(32'h0000_0001);
    chk(32'(idx), 32'h0000_0018);
    // fatal answer with its interrupt masked first
    shrt <= 1'b0;
    fat <= 1'b1;
    wr(tdd_pkg::OFF_ENABLE, 32'h0000_0001);
    run(2'b01, 11'h008, 15'h0018, 32'h0, 32'h0, 32'h0000_00FF, 32'h0);
    chk(32'(q_len.size()), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    wr(tdd_pkg::OFF_ENABLE, 32'h0000_0007);
    fin(32'h0000_0002);
    // multiplier zero is refused without a packet
    fat <= 1'b0;
    run(2'b00, 11'h008, 15'h0018, 32'h0, 32'h0, 32'h0000_00FF, 32'h0);
    chk(32'(q_len.size()), 32'h0000_0000);
    fin(32'h0000_0004);
    $display("test errors done");
    // every polling rate: ticks between the two packets of a descriptor
    dly <= 4'h2;
    for (int i = 0; i < 10; i++) begin
      run(2'b01, 11'h008, 15'h0010, 32'h0, 32'(per[i]) << tdd_pkg::PERIOD_LSB,
          32'(msk[i]), 32'h0);
      chk(32'(q_tick[1] - q_tick[0]), 32'(iv[i]));
      fin(32'h0000_0001);
    end
    $display("test polling done");
    results();
  end
  // a hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule // tb_top
`default_nettype wire
